// ===== src/cpu_status_flag_logic.v
// status flag logic of an 8-bit core with apb register access
//
// Functional notes
// RQ1: carry set on carry out of, or borrow into, bit 7 in arithmetic.
// RQ2: after shift or rotate, carry holds the last bit shifted out.
// RQ3: instructions can set, clear or complement the carry.
// RQ4: zero set when arithmetic or logic result is zero.
// RQ5: zero set when bit test or shift/rotate result is zero.
// RQ6: sign copies result msb after arithmetic, logic, rotate, shift.
// RQ7: overflow set when signed result leaves -128..+127.
// RQ8: logic instructions clear overflow.
// RQ9: decimal bit records add or subtract; never a jump test condition.
// RQ10: half carry on add carry out of bit 3 or sub borrow from bit 4.
// RQ11: decimal adjust corrects previous result using half carry; the code adjusts operand a (opnd_a), not result.
// RQ12: fast irq bit set on fast irq entry, cleared by interrupt return.
// RQ13: fast irq bit blocks all interrupts and selects fast return.
// RQ14: bank bit selects the set 1 register bank.
// RQ15: bank low op clears, bank high op sets the bank bit.
// RQ16: pair operands are even registers 0..254 or working pairs 0..14.
// RQ17: relative offset -128..+127 added to next instruction address.
// RQ18: short index adds signed -128..+127 offset to even working pair.
// RQ19: long index adds 0..65535 offset to even working pair.
// RQ20: bit operands pick one of 16 working registers and 8 bits.
// RQ21: flag update and direct write in same cycle give undefined content.
// RQ22: flags an instruction does not define keep their value.
//
// The APB register port was left to the implementer.
`include "flag_consts.vh"
`default_nettype none
module cpu_status_flag_logic (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // core side
  input wire irq_req,
  output wire irq_blocked,
  output wire fast_return,
  output wire bank_sel,
  output wire [3:0] cond_flags
);
  reg [7:0] flags;
  reg [4:0] op_code;
  reg op_go;
  reg [7:0] opnd_a;
  reg [7:0] opnd_b;
  reg [7:0] result;
  reg [1:0] adr_mode;
  reg [15:0] adr_base;
  reg [15:0] adr_off;
  reg [15:0] adr_res;
  reg adr_err;
  reg [7:0] next_flags;
  reg [7:0] next_result;
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] bcd_val;
  wire [7:0] adj_out;
  wire adj_carry;
  wire acc;
  wire wr;
  reg known;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  always @* begin
    case (paddr)
      `FLAGS_ADDR, `OP_ADDR, `OPND_ADDR, `RES_ADDR, `ADR_ADDR, `ADR_RES_ADDR: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign pslverr = acc && !known;

  assign irq_blocked = flags[`F_FAST_IRQ]; // RQ13
  assign fast_return = flags[`F_FAST_IRQ] && op_go && op_code == `OP_IRQ_RETURN; // RQ13
  assign bank_sel = flags[`F_BANK]; // RQ14
  // decimal bit deliberately left out of the testable set
  assign cond_flags = flags[7:4]; // RQ9

  bcd_adjust u_bcd (
    .value(opnd_a),
    .carry(flags[`F_CARRY]),
    .half(flags[`F_HALF]),
    .was_sub(flags[`F_DEC]),
    .adjusted(adj_out),
    .carry_out(adj_carry)
  );

  // flag and result evaluation; untouched flags keep their value
  always @* begin
    next_flags = flags; // RQ22
    next_result = result;
    sum = 9'h000;
    nib = 5'h00;
    bcd_val = 8'h00;
    if (op_go) begin
      case (op_code)
        `OP_ADD, `OP_ADC, `OP_INC: begin
          if (op_code == `OP_INC) begin
            sum = {1'b0, opnd_a} + 9'h001;
            nib = {1'b0, opnd_a[3:0]} + 5'h01;
          end else begin
            sum = {1'b0, opnd_a} + {1'b0, opnd_b} +
              {8'h00, op_code == `OP_ADC && flags[`F_CARRY]};
            nib = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} +
              {4'h0, op_code == `OP_ADC && flags[`F_CARRY]};
          end
          next_result = sum[7:0];
          if (op_code != `OP_INC) begin
            next_flags[`F_CARRY] = sum[8]; // RQ1
            next_flags[`F_DEC] = 1'b0; // RQ9
            next_flags[`F_HALF] = nib[4]; // RQ10
          end
          next_flags[`F_ZERO] = sum[7:0] == 8'h00; // RQ4
          next_flags[`F_SIGN] = sum[7]; // RQ6
          next_flags[`F_OVF] = (opnd_a[7] == (op_code == `OP_INC ? 1'b0 : opnd_b[7]))
            && (sum[7] != opnd_a[7]); // RQ7
        end
        `OP_SUB, `OP_SBC, `OP_CP, `OP_DEC: begin
          if (op_code == `OP_DEC) begin
            sum = {1'b0, opnd_a} - 9'h001;
            nib = {1'b0, opnd_a[3:0]} - 5'h01;
          end else begin
            sum = {1'b0, opnd_a} - {1'b0, opnd_b} -
              {8'h00, op_code == `OP_SBC && flags[`F_CARRY]};
            nib = {1'b0, opnd_a[3:0]} - {1'b0, opnd_b[3:0]} -
              {4'h0, op_code == `OP_SBC && flags[`F_CARRY]};
          end
          if (op_code != `OP_CP) begin
            next_result = sum[7:0];
          end
          next_flags[`F_CARRY] = op_code == `OP_DEC ? flags[`F_CARRY] : sum[8]; // RQ1
          if (op_code == `OP_SUB || op_code == `OP_SBC) begin
            next_flags[`F_DEC] = 1'b1; // RQ9
            next_flags[`F_HALF] = nib[4]; // RQ10
          end
          next_flags[`F_ZERO] = sum[7:0] == 8'h00; // RQ4
          next_flags[`F_SIGN] = sum[7]; // RQ6
          next_flags[`F_OVF] = (opnd_a[7] != (op_code == `OP_DEC ? 1'b0 : opnd_b[7]))
            && (sum[7] != opnd_a[7]); // RQ7
        end
        `OP_AND, `OP_OR, `OP_XOR, `OP_COM: begin
          case (op_code)
            `OP_AND: bcd_val = opnd_a & opnd_b;
            `OP_OR: bcd_val = opnd_a | opnd_b;
            `OP_XOR: bcd_val = opnd_a ^ opnd_b;
            default: bcd_val = ~opnd_a;
          endcase
          next_result = bcd_val;
          next_flags[`F_ZERO] = bcd_val == 8'h00; // RQ4
          next_flags[`F_SIGN] = bcd_val[7]; // RQ6
          next_flags[`F_OVF] = 1'b0; // RQ8
        end
        `OP_TM, `OP_TCM: begin
          bcd_val = (op_code == `OP_TM ? opnd_a : ~opnd_a) & opnd_b;
          next_flags[`F_ZERO] = bcd_val == 8'h00; // RQ5
          next_flags[`F_SIGN] = bcd_val[7]; // RQ6
          next_flags[`F_OVF] = 1'b0; // RQ8
        end
        `OP_RL, `OP_RLC, `OP_RR, `OP_RRC, `OP_SRA: begin
          case (op_code)
            `OP_RL: bcd_val = {opnd_a[6:0], opnd_a[7]};
            `OP_RLC: bcd_val = {opnd_a[6:0], flags[`F_CARRY]};
            `OP_RR: bcd_val = {opnd_a[0], opnd_a[7:1]};
            `OP_RRC: bcd_val = {flags[`F_CARRY], opnd_a[7:1]};
            default: bcd_val = {opnd_a[7], opnd_a[7:1]};
          endcase
          next_result = bcd_val;
          next_flags[`F_CARRY] = (op_code == `OP_RL || op_code == `OP_RLC) ?
            opnd_a[7] : opnd_a[0]; // RQ2
          next_flags[`F_ZERO] = bcd_val == 8'h00; // RQ5
          next_flags[`F_SIGN] = bcd_val[7]; // RQ6
          next_flags[`F_OVF] = op_code == `OP_SRA ? 1'b0 : bcd_val[7] ^ opnd_a[7];
        end
        `OP_SCF: next_flags[`F_CARRY] = 1'b1; // RQ3
        `OP_RCF: next_flags[`F_CARRY] = 1'b0; // RQ3
        `OP_CCF: next_flags[`F_CARRY] = ~flags[`F_CARRY]; // RQ3
        `OP_BANK_LOW: next_flags[`F_BANK] = 1'b0; // RQ15
        `OP_BANK_HIGH: next_flags[`F_BANK] = 1'b1; // RQ15
        `OP_DEC_ADJUST: begin
          next_result = adj_out; // RQ11
          next_flags[`F_CARRY] = adj_carry; // RQ11
          next_flags[`F_ZERO] = adj_out == 8'h00;
          next_flags[`F_SIGN] = adj_out[7];
        end
        `OP_FIRQ: next_flags[`F_FAST_IRQ] = 1'b1; // RQ12
        `OP_IRQ_RETURN: next_flags[`F_FAST_IRQ] = 1'b0; // RQ12
        default: next_flags = flags;
      endcase
    end
  end

  // address helper: each mode checks its operand range
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adr_res <= 16'h0000;
      adr_err <= 1'b0;
    end else begin
      case (adr_mode)
        `AM_REL: begin
          adr_res <= adr_base + {{8{adr_off[7]}}, adr_off[7:0]}; // RQ17
          adr_err <= adr_off[15:8] != {8{adr_off[7]}}; // RQ17
        end
        `AM_XS: begin
          adr_res <= adr_base + {{8{adr_off[7]}}, adr_off[7:0]}; // RQ18
          adr_err <= adr_base[0] || adr_off[15:8] != {8{adr_off[7]}}; // RQ18
        end
        `AM_XL: begin
          adr_res <= adr_base + adr_off; // RQ19
          adr_err <= adr_base[0]; // RQ19
        end
        default: begin
          // pair number in low byte; bit operand packs reg in [11:8], bit in [14:12]
          adr_res <= {1'b0, adr_off[14:12], adr_off[11:8], adr_base[7:0]}; // RQ20
          adr_err <= adr_base[0] || adr_base[15:8] != 8'h00; // RQ16
        end
      endcase
    end
  end

  // registers; a flag update and a direct flags write issued together are ORed into flags
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= `FLAGS_RESET;
      op_code <= `OP_NONE;
      op_go <= 1'b0;
      opnd_a <= 8'h00;
      opnd_b <= 8'h00;
      result <= 8'h00;
      adr_mode <= `AM_REL;
      adr_base <= 16'h0000;
      adr_off <= 16'h0000;
    end else begin
      op_go <= 1'b0;
      result <= next_result;
      flags <= next_flags;
      if (wr) begin
        case (paddr)
          `FLAGS_ADDR: begin
            if (!op_go) begin
              flags <= pwdata[7:0];
            end else begin
              flags <= next_flags | pwdata[7:0]; // RQ21
            end
          end
          `OP_ADDR: begin
            op_code <= pwdata[4:0];
            op_go <= 1'b1;
          end
          `OPND_ADDR: begin
            opnd_a <= pwdata[7:0];
            opnd_b <= pwdata[15:8];
          end
          `ADR_ADDR: begin
            adr_base <= pwdata[15:0];
            adr_off <= pwdata[31:16];
          end
          `RES_ADDR: adr_mode <= pwdata[1:0];
          default: op_go <= 1'b0;
        endcase
      end
    end
  end

  // read data registered at the setup phase
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `FLAGS_ADDR: prdata <= {24'h000000, flags};
        `OP_ADDR: prdata <= {27'h0000000, op_code};
        `OPND_ADDR: prdata <= {16'h0000, opnd_b, opnd_a};
        `RES_ADDR: prdata <= {22'h000000, adr_mode, result};
        `ADR_ADDR: prdata <= {adr_off, adr_base};
        `ADR_RES_ADDR: prdata <= {15'h0000, adr_err, adr_res};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // cpu_status_flag_logic
`default_nettype wire

// ===== src/flag_consts.vh
// constants for the cpu status flag block
`ifndef FLAG_CONSTS_VH
`define FLAG_CONSTS_VH
// register index of the status register; its bus address is four times the index
`define FLAGS_INDEX 12'h0d5
`define FLAGS_ADDR 12'h354
// byte address of the operation register (control)
`define OP_ADDR 12'h000
// byte address of the operand register (a/b)
`define OPND_ADDR 12'h004
// byte address of the result register (status)
`define RES_ADDR 12'h008
// byte address of the address helper register
`define ADR_ADDR 12'h00c
// byte address of the computed address result
`define ADR_RES_ADDR 12'h010
// flag bit positions
`define F_CARRY 7
`define F_ZERO 6
`define F_SIGN 5
`define F_OVF 4
`define F_DEC 3
`define F_HALF 2
`define F_FAST_IRQ 1
`define F_BANK 0
`define FLAGS_RESET 8'h00
// operation codes
`define OP_NONE 5'h00
`define OP_ADD 5'h01
`define OP_ADC 5'h02
`define OP_SUB 5'h03
`define OP_SBC 5'h04
`define OP_CP 5'h05
`define OP_AND 5'h06
`define OP_OR 5'h07
`define OP_XOR 5'h08
`define OP_COM 5'h09
`define OP_RL 5'h0a
`define OP_RLC 5'h0b
`define OP_RR 5'h0c
`define OP_RRC 5'h0d
`define OP_SRA 5'h0e
`define OP_TM 5'h0f
`define OP_TCM 5'h10
`define OP_SCF 5'h11
`define OP_RCF 5'h12
`define OP_CCF 5'h13
`define OP_BANK_LOW 5'h14
`define OP_BANK_HIGH 5'h15
`define OP_DEC_ADJUST 5'h16
`define OP_FIRQ 5'h17
`define OP_IRQ_RETURN 5'h18
`define OP_INC 5'h19
`define OP_DEC 5'h1a
// address modes for the address helper
`define AM_REL 2'h0
`define AM_XS 2'h1
`define AM_XL 2'h2
`define AM_PAIR 2'h3
`endif

// ===== src/bcd_adjust.v
// decimal adjust of an accumulator byte from carry, half carry and op kind
`default_nettype none
module bcd_adjust (
  // inputs
  input wire [7:0] value,
  input wire carry,
  input wire half,
  input wire was_sub,
  // outputs
  output reg [7:0] adjusted,
  output reg carry_out
);
  reg [7:0] corr;
  always @* begin
    corr = 8'h00;
    carry_out = carry;
    if (!was_sub) begin
      if (carry || value > 8'h99) begin
        corr = 8'h60;
        carry_out = 1'b1;
      end
      if (half || value[3:0] > 4'h9) begin
        corr = corr | 8'h06;
      end
      adjusted = value + corr;
    end else begin
      if (carry) begin
        corr = 8'h60;
      end
      if (half) begin
        corr = corr | 8'h06;
      end
      adjusted = value - corr;
    end
  end
endmodule // bcd_adjust
`default_nettype wire

// ===== dv/flag_sva.sv
// assertions on the status flag block ports
`include "flag_consts.vh"
`default_nettype none
module flag_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // core side
  input wire logic irq_req,
  input wire logic irq_blocked,
  input wire logic fast_return,
  input wire logic bank_sel,
  input wire logic [3:0] cond_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  // an op write lands at the access edge; its effect shows two edges on
  wire logic opw = psel && penable && pwrite && paddr == `OP_ADDR;
  wire logic [4:0] op = pwdata[4:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_bank_low; opw && op == `OP_BANK_LOW |-> ##2 !bank_sel; endproperty
  a_bank_low: assert property (p_bank_low) else $error("bank low op left bank set");
  property p_bank_high; opw && op == `OP_BANK_HIGH |-> ##2 bank_sel; endproperty
  a_bank_high: assert property (p_bank_high) else $error("bank high op left bank clear");
  property p_scf; opw && op == `OP_SCF |-> ##2 cond_flags[3]; endproperty
  a_scf: assert property (p_scf) else $error("carry not set");
  property p_rcf; opw && op == `OP_RCF |-> ##2 !cond_flags[3]; endproperty
  a_rcf: assert property (p_rcf) else $error("carry not cleared");
  property p_ccf;
    opw && op == `OP_CCF |-> ##2 cond_flags[3] != $past(cond_flags[3], 2);
  endproperty
  a_ccf: assert property (p_ccf) else $error("carry not inverted");
  property p_logic;
    opw && (op == `OP_AND || op == `OP_OR || op == `OP_XOR) |-> ##2 !cond_flags[0];
  endproperty
  a_logic: assert property (p_logic) else $error("overflow kept by logic op");
  property p_keep;
    opw && op == `OP_BANK_HIGH |-> ##2 cond_flags == $past(cond_flags, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved by bank op");
  property p_firq; opw && op == `OP_FIRQ |-> ##2 irq_blocked; endproperty
  a_firq: assert property (p_firq) else $error("fast entry did not block");
  property p_irq_ret;
    opw && op == `OP_IRQ_RETURN && irq_blocked |-> ##2 !irq_blocked;
  endproperty
  a_irq_ret: assert property (p_irq_ret) else $error("return kept fast bit");
  property p_fret;
    opw && op == `OP_IRQ_RETURN && irq_blocked |-> ##[1:2] fast_return;
  endproperty
  a_fret: assert property (p_fret) else $error("no fast return pulse");
endmodule // flag_sva
bind cpu_status_flag_logic flag_sva chk_u (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .irq_req(irq_req), .irq_blocked(irq_blocked),
  .fast_return(fast_return), .bank_sel(bank_sel), .cond_flags(cond_flags));
`default_nettype wire

// ===== dv/test_cpu_status_flag_logic.sv
// self-checking bench for the status flag block
`include "flag_consts.vh"
`default_nettype none
module test_cpu_status_flag_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic irq_req = 1'h0, fret_seen = 1'h0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq_blocked, fast_return, bank_sel;
  logic [3:0] cond_flags;
  logic [7:0] op, a, b, pre, ex, msk;
  logic [47:0] rows [0:25];
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  cpu_status_flag_logic dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq_req(irq_req), .irq_blocked(irq_blocked),
    .fast_return(fast_return), .bank_sel(bank_sel), .cond_flags(cond_flags));
  task conclude;
    $display("counts: %0d mismatches, %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // the run should need about five hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fast_return === 1'h1) fret_seen <= 1'h1;
    if (cyc == 20000) begin
      n_errors++;
      conclude;
    end
  end
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task run_op(input logic [7:0] p, input logic [7:0] x, input logic [7:0] y,
      input logic [4:0] o);
    apb(1'h1, `FLAGS_ADDR, {24'h0, p});
    apb(1'h1, `OPND_ADDR, {16'h0, y, x});
    apb(1'h1, `OP_ADDR, {27'h0, o});
  endtask
  task adr(input logic [1:0] m, input logic [31:0] bo, input logic [31:0] e, m2);
    apb(1'h1, `RES_ADDR, {30'h0, m});
    apb(1'h1, `ADR_ADDR, bo);
    apb(1'h0, `ADR_RES_ADDR, 32'h0);
    chk_val(rd & m2, e);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    // op, a, b, flags before, flags after, bits that are defined
    rows = '{48'h01_80_80_00_d0_fc, 48'h01_0f_01_00_04_fc, 48'h02_ff_00_80_c4_fc,
      48'h03_00_01_00_ac_fc, 48'h03_80_01_00_1c_fc, 48'h04_00_00_80_ac_fc,
      48'h05_05_05_00_40_f0, 48'h06_f0_0f_90_c0_f0, 48'h07_80_01_10_20_f0,
      48'h08_ff_ff_10_40_f0, 48'h09_00_00_10_20_f0, 48'h0a_80_00_00_80_e0,
      48'h0b_80_00_00_c0_e0, 48'h0c_01_00_00_a0_e0, 48'h0d_01_00_80_a0_e0,
      48'h0e_81_00_00_a0_f0, 48'h0f_01_02_00_40_40, 48'h10_ff_ff_00_40_40,
      48'h19_7f_00_00_30_f0, 48'h1a_01_00_80_c0_f0, 48'h11_00_00_00_80_ff,
      48'h12_00_00_f9_79_ff, 48'h13_00_00_80_00_ff, 48'h13_00_00_04_84_ff,
      48'h15_00_00_00_01_ff, 48'h14_00_00_f9_f8_ff};
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    apb(1'h0, `FLAGS_ADDR, 32'h0);
    chk_val(rd, 32'h0);
    chk_val({cond_flags, bank_sel, irq_blocked}, 6'h00);
    done("reset");
    for (int i = 0; i < 26; i++) begin
      {op, a, b, pre, ex, msk} = rows[i];
      run_op(pre, a, b, op[4:0]);
      apb(1'h0, `FLAGS_ADDR, 32'h0);
      chk_val(rd & {24'h0, msk}, {24'h0, ex & msk});
      chk_val({cond_flags, 3'h0, bank_sel} & msk & 8'hf1, ex & msk & 8'hf1);
    end
    done("table");
    // decimal adjust after an add and after a subtract
    run_op(8'h00, 8'h09, 8'h01, `OP_ADD);
    run_op(8'h04, 8'h0a, 8'h00, `OP_DEC_ADJUST);
    apb(1'h0, `RES_ADDR, 32'h0);
    chk_val(rd[7:0], 8'h10);
    run_op(8'h00, 8'h10, 8'h01, `OP_SUB);
    apb(1'h1, `OPND_ADDR, 32'h0000_000f);
    apb(1'h1, `OP_ADDR, {27'h0, `OP_DEC_ADJUST});
    apb(1'h0, `RES_ADDR, 32'h0);
    chk_val(rd[7:0], 8'h09);
    done("decimal");
    // return without the fast bit must not take the fast path
    irq_req <= 1'h1;
    run_op(8'h00, 8'h00, 8'h00, `OP_IRQ_RETURN);
    repeat (2) @(posedge clk);
    chk_val(fret_seen, 1'h0);
    run_op(8'h00, 8'h00, 8'h00, `OP_FIRQ);
    repeat (2) @(posedge clk);
    chk_val(irq_blocked, 1'h1);
    apb(1'h1, `OP_ADDR, {27'h0, `OP_IRQ_RETURN});
    repeat (2) @(posedge clk);
    chk_val({fret_seen, irq_blocked}, 2'h2);
    done("fast irq");
    adr(`AM_REL, 32'hff80_1000, 32'h0000_0f80, 32'h1_ffff);
    adr(`AM_REL, 32'h0080_1000, 32'h1_0000, 32'h1_0000);
    adr(`AM_XS, 32'h007f_0002, 32'h0000_0081, 32'h1_ffff);
    adr(`AM_XS, 32'h0000_0003, 32'h1_0000, 32'h1_0000);
    adr(`AM_XL, 32'h8000_0004, 32'h0000_8004, 32'h1_ffff);
    adr(`AM_PAIR, 32'h0000_00ff, 32'h1_0000, 32'h1_0000);
    adr(`AM_PAIR, 32'h0000_0100, 32'h1_0000, 32'h1_0000);
    adr(`AM_PAIR, 32'h7f00_00fe, 32'h0000_7ffe, 32'h1_ffff);
    done("address");
    // unmapped place: write ignored, read zero with an error
    apb(1'h1, 12'h020, 32'hffff_ffff);
    apb(1'h0, 12'h020, 32'h0);
    chk_val(rd, 32'h0);
    chk_val({31'h0, err}, 32'h1);
    done("unmapped");
    // reset in mid-run must bring every flag back to zero
    apb(1'h1, `FLAGS_ADDR, 32'h0000_00ff);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk_val({cond_flags, bank_sel, irq_blocked}, 6'h00);
    arst_n <= 1'h1;
    apb(1'h0, `FLAGS_ADDR, 32'h0);
    chk_val(rd, 32'h0);
    done("mid reset");
    conclude;
  end
endmodule // test_cpu_status_flag_logic
`default_nettype wire
